/* hw/msfsm_defs.vh */
/*
 Constants of the max-address security command handler: opcodes, feature
 codes, security states, status and error bit values and sector layout.
 Assumes inclusion by its bare name from the design files.
*/
`ifndef MSFSM_DEFS_VH
`define MSFSM_DEFS_VH

// Task-file opcodes that the handler watches.
`define MSFSM_OP_SET_MAX 8'hf9
`define MSFSM_OP_READ_NATIVE 8'hf8

// Feature codes of the security sub-commands.
`define MSFSM_FT_SET_PWD 8'h01
`define MSFSM_FT_LOCK 8'h02
`define MSFSM_FT_UNLOCK 8'h03
`define MSFSM_FT_FREEZE 8'h04

// Security states.
`define MSFSM_SEC_UNLOCKED 2'h0
`define MSFSM_SEC_LOCKED 2'h1
`define MSFSM_SEC_FROZEN 2'h2

// Unlock attempt counter.
`define MSFSM_TRIES_INIT 3'h5
`define MSFSM_TRIES_ZERO 3'h0
`define MSFSM_TRIES_STEP 3'h1

// Data sector layout in 16-bit words.
`define MSFSM_WORD_FIRST 8'h00
`define MSFSM_WORD_LAST 8'hff
`define MSFSM_PWD_FIRST 8'h01
`define MSFSM_PWD_LAST 8'h10
`define MSFSM_WORD_STEP 8'h01

// Status and error values on completion and at reset.
`define MSFSM_STATUS_OK 8'h40
`define MSFSM_STATUS_ERR 8'h41
`define MSFSM_STATUS_IDLE 8'h40
`define MSFSM_ERROR_ABORT 8'h04
`define MSFSM_ERROR_NONE 8'h00

// Head field of the device/head register.
`define MSFSM_HEAD_MSB 27
`define MSFSM_HEAD_LSB 24
`define MSFSM_HEAD_ZERO 4'h0

`endif

/* hw/msfsm_pwd.v */
/*
 Volatile password store and comparator of the max-address security handler.
 Assumes words arrive one per cycle from the handler, on the handler's clock.
*/
`timescale 1ns/100ps
`include "msfsm_defs.vh"

module msfsm_pwd #(
   parameter W = 16,
   parameter N = 16,
   parameter IW = 4
) (
   input wire clk_i,
   input wire resetn_i,
   input wire clear_i,
   input wire start_i,
   input wire wr_i,
   input wire cmp_i,
   input wire [IW-1:0] idx_i,
   input wire [W-1:0] word_i,
   output reg mismatch_o
);

   reg [W-1:0] pwd_r [0:N-1];
   integer i;

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (i = 0; i < N; i = i + 1) begin
            pwd_r[i] <= {W{1'b0}};
         end
         mismatch_o <= 1'b0;
      end else if (clear_i) begin
         for (i = 0; i < N; i = i + 1) begin
            pwd_r[i] <= {W{1'b0}};
         end
         mismatch_o <= 1'b0;
      end else begin
         if (start_i) begin
            mismatch_o <= 1'b0;
         end
         if (wr_i) begin
            pwd_r[idx_i] <= word_i;
         end
         if (cmp_i && (pwd_r[idx_i] != word_i)) begin
            mismatch_o <= 1'b1;
         end
      end
   end

endmodule

/* hw/msfsm_top.v */
/*
 Command handler for the security extensions of the max-address command.
 Assumes a task-file decoder on the same clock that presents each command
 as a one-cycle strobe and data words as one-cycle strobes while asked for.
*/
`timescale 1ns/100ps
`include "msfsm_defs.vh"

module msfsm_top #(
   parameter PWD_WORDS = 16,
   parameter WORD_W = 16
) (
   input wire clk_i,
   input wire resetn_i,
   input wire hard_reset_i,
   input wire cmd_valid_i,
   input wire [7:0] cmd_code_i,
   input wire [7:0] feature_i,
   input wire lba_mode_i,
   input wire [27:0] max_addr_i,
   input wire [3:0] max_head_i,
   input wire data_valid_i,
   input wire [WORD_W-1:0] data_i,
   output reg busy_o,
   output reg drq_o,
   output reg done_o,
   output reg [7:0] status_o,
   output reg [7:0] error_o,
   output reg [3:0] head_o,
   output reg set_max_o,
   output reg read_native_o,
   output reg [1:0] sec_state_o,
   output reg [2:0] tries_o
);

   localparam S_IDLE = 2'b00;
   localparam S_XFER = 2'b01;
   localparam S_FIN = 2'b10;

   localparam OP_NONE = 3'b000;
   localparam OP_PWD = 3'b001;
   localparam OP_LOCK = 3'b010;
   localparam OP_UNLOCK = 3'b011;
   localparam OP_FREEZE = 3'b100;

   localparam PWD_IW = 4;

   reg [1:0] fsm_r;
   reg [2:0] op_r;
   reg ok_r;
   reg prev_native_r;
   reg [7:0] word_cnt_r;

   wire xfer_word;
   wire in_pwd;
   wire [7:0] pwd_off;
   wire pwd_mismatch;
   wire pwd_start;
   wire pwd_wr;
   wire pwd_cmp;

   // Completion status and error pair.
   function [15:0] f_resp;
      input ok;
      begin
         if (ok) begin
            f_resp = {`MSFSM_STATUS_OK, `MSFSM_ERROR_NONE};
         end else begin
            f_resp = {`MSFSM_STATUS_ERR, `MSFSM_ERROR_ABORT};
         end
      end
   endfunction

   // Head field returned on completion.
   function [3:0] f_head;
      input lba;
      input [27:0] addr;
      input [3:0] head;
      begin
         if (lba) begin
            f_head = addr[`MSFSM_HEAD_MSB:`MSFSM_HEAD_LSB];
         end else begin
            f_head = head;
         end
      end
   endfunction

   // True in the state that admits guarded sub-commands.
   function f_unlocked;
      input [1:0] state;
      begin
         f_unlocked = (state == `MSFSM_SEC_UNLOCKED);
      end
   endfunction

   assign xfer_word = (fsm_r == S_XFER) && data_valid_i;
   assign in_pwd = (word_cnt_r >= `MSFSM_PWD_FIRST) && (word_cnt_r <= `MSFSM_PWD_LAST);
   assign pwd_off = word_cnt_r - `MSFSM_PWD_FIRST;
   assign pwd_start = (fsm_r == S_IDLE) && cmd_valid_i;
   assign pwd_wr = xfer_word && in_pwd && (op_r == OP_PWD);
   assign pwd_cmp = xfer_word && in_pwd && (op_r == OP_UNLOCK);

   msfsm_pwd #(
      .W(WORD_W),
      .N(PWD_WORDS),
      .IW(PWD_IW)
   ) u_pwd (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .clear_i(hard_reset_i),
      .start_i(pwd_start),
      .wr_i(pwd_wr),
      .cmp_i(pwd_cmp),
      .idx_i(pwd_off[PWD_IW-1:0]),
      .word_i(data_i),
      .mismatch_o(pwd_mismatch)
   );

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fsm_r <= S_IDLE;
         op_r <= OP_NONE;
         ok_r <= 1'b0;
         prev_native_r <= 1'b0;
         word_cnt_r <= `MSFSM_WORD_FIRST;
         busy_o <= 1'b0;
         drq_o <= 1'b0;
         done_o <= 1'b0;
         status_o <= `MSFSM_STATUS_IDLE;
         error_o <= `MSFSM_ERROR_NONE;
         head_o <= `MSFSM_HEAD_ZERO;
         set_max_o <= 1'b0;
         read_native_o <= 1'b0;
         sec_state_o <= `MSFSM_SEC_UNLOCKED;
         tries_o <= `MSFSM_TRIES_INIT;
      end else if (hard_reset_i) begin
         fsm_r <= S_IDLE;
         op_r <= OP_NONE;
         ok_r <= 1'b0;
         prev_native_r <= 1'b0;
         word_cnt_r <= `MSFSM_WORD_FIRST;
         busy_o <= 1'b0;
         drq_o <= 1'b0;
         done_o <= 1'b0;
         set_max_o <= 1'b0;
         read_native_o <= 1'b0;
         sec_state_o <= `MSFSM_SEC_UNLOCKED;
         tries_o <= `MSFSM_TRIES_INIT;
      end else begin
         done_o <= 1'b0;
         set_max_o <= 1'b0;
         read_native_o <= 1'b0;
         case (fsm_r)
            S_IDLE: begin
               if (cmd_valid_i) begin
                  if (cmd_code_i == `MSFSM_OP_READ_NATIVE) begin
                     prev_native_r <= 1'b1;
                  end else if (cmd_code_i == `MSFSM_OP_SET_MAX) begin
                     prev_native_r <= 1'b0;
                     busy_o <= 1'b1;
                     fsm_r <= S_FIN;
                     op_r <= OP_NONE;
                     word_cnt_r <= `MSFSM_WORD_FIRST;
                     if (prev_native_r) begin
                        if (feature_i == `MSFSM_FT_LOCK) begin
                           read_native_o <= 1'b1;
                           prev_native_r <= 1'b1;
                           ok_r <= 1'b1;
                        end else if (!f_unlocked(sec_state_o)) begin
                           // setting aborted when locked or frozen
                           ok_r <= 1'b0;
                        end else begin
                           set_max_o <= 1'b1;
                           ok_r <= 1'b1;
                        end
                     end else begin
                        case (feature_i)
                           `MSFSM_FT_SET_PWD: begin
                              if (f_unlocked(sec_state_o)) begin
                                 ok_r <= 1'b1;
                                 op_r <= OP_PWD;
                                 drq_o <= 1'b1;
                                 fsm_r <= S_XFER;
                              end else begin
                                 ok_r <= 1'b0;
                              end
                           end
                           `MSFSM_FT_LOCK: begin
                              ok_r <= f_unlocked(sec_state_o);
                              op_r <= OP_LOCK;
                           end
                           `MSFSM_FT_UNLOCK: begin
                              if ((sec_state_o == `MSFSM_SEC_FROZEN) || (tries_o == `MSFSM_TRIES_ZERO)) begin
                                 ok_r <= 1'b0;
                              end else begin
                                 ok_r <= 1'b1;
                                 op_r <= OP_UNLOCK;
                                 drq_o <= 1'b1;
                                 fsm_r <= S_XFER;
                              end
                           end
                           `MSFSM_FT_FREEZE: begin
                              ok_r <= (sec_state_o != `MSFSM_SEC_FROZEN);
                              op_r <= OP_FREEZE;
                           end
                           default: begin
                              ok_r <= 1'b0;
                           end
                        endcase
                     end
                  end else begin
                     prev_native_r <= 1'b0;
                  end
               end
            end
            S_XFER: begin
               if (data_valid_i) begin
                  word_cnt_r <= word_cnt_r + `MSFSM_WORD_STEP;
                  if (word_cnt_r == `MSFSM_WORD_LAST) begin
                     drq_o <= 1'b0;
                     fsm_r <= S_FIN;
                  end
               end
            end
            S_FIN: begin
               fsm_r <= S_IDLE;
               busy_o <= 1'b0;
               done_o <= 1'b1;
               head_o <= f_head(lba_mode_i, max_addr_i, max_head_i);
               {status_o, error_o} <= f_resp(ok_r && !((op_r == OP_UNLOCK) && pwd_mismatch));
               if (ok_r) begin
                  case (op_r)
                     OP_LOCK: begin
                        sec_state_o <= `MSFSM_SEC_LOCKED;
                     end
                     OP_FREEZE: begin
                        sec_state_o <= `MSFSM_SEC_FROZEN;
                     end
                     OP_UNLOCK: begin
                        if (pwd_mismatch) begin
                           if (tries_o != `MSFSM_TRIES_ZERO) begin
                              tries_o <= tries_o - `MSFSM_TRIES_STEP;
                           end
                        end else begin
                           sec_state_o <= `MSFSM_SEC_UNLOCKED;
                        end
                     end
                     default: begin
                        sec_state_o <= sec_state_o;
                     end
                  endcase
               end
            end
            default: begin
               fsm_r <= S_IDLE;
            end
         endcase
      end
   end

endmodule

/* sim/msfsm_host.sv */
/*
 Host adapter model that answers each data request with one sector.
 Assumes the handler's drq_o and clock; words change at the falling edge.
*/
`timescale 1ns/100ps
module msfsm_host (
   input wire clk_i,
   input wire drq_i,
   input wire slow_i,
   input wire [15:0] key_i,
   output reg data_valid_o,
   output reg [15:0] data_o
);
   integer k;
   initial begin
      data_valid_o = 1'b0;
      data_o = 16'h0000;
      k = 0;
   end
   always @(negedge clk_i) begin
      if (drq_i && k < 256 && !(slow_i && $random % 3 == 0)) begin
         data_valid_o <= 1'b1;
         data_o <= (k >= 1 && k <= 16) ? key_i ^ k[15:0] : ~key_i;
         k <= k + 1;
      end else begin
         data_valid_o <= 1'b0;
         data_o <= ~data_o;
         if (!drq_i) begin
            k <= 0;
         end
      end
   end
endmodule

/* sim/msfsm_top_chk.sv */
/*
 Assertion checker for the max-address security handler.
 Assumes it is bound to msfsm_top and sees only its ports.
*/
`timescale 1ns/100ps
module msfsm_top_chk #(
   parameter PWD_WORDS = 16,
   parameter WORD_W = 16
) (
   input wire clk_i,
   input wire resetn_i,
   input wire hard_reset_i,
   input wire cmd_valid_i,
   input wire [7:0] cmd_code_i,
   input wire [7:0] feature_i,
   input wire lba_mode_i,
   input wire [27:0] max_addr_i,
   input wire [3:0] max_head_i,
   input wire data_valid_i,
   input wire [WORD_W-1:0] data_i,
   input wire busy_o,
   input wire drq_o,
   input wire done_o,
   input wire [7:0] status_o,
   input wire [7:0] error_o,
   input wire [3:0] head_o,
   input wire set_max_o,
   input wire read_native_o,
   input wire [1:0] sec_state_o,
   input wire [2:0] tries_o
);
   reg mark_r;
   reg [8:0] wcnt_r;
   wire take = cmd_valid_i && !busy_o && !drq_o && cmd_code_i == 8'hf9;
   wire sec = !mark_r && take;
   wire plain = mark_r && take && sec_state_o == 2'h0;
   wire guarded = sec_state_o == 2'h2 || (sec_state_o == 2'h1 && feature_i != 8'h03 && feature_i != 8'h04);
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mark_r <= 1'b0;
         wcnt_r <= 9'h000;
      end else begin
         if (hard_reset_i) begin
            mark_r <= 1'b0;
         end else if (cmd_valid_i && !busy_o && !drq_o) begin
            mark_r <= cmd_code_i == 8'hf8 || (mark_r && take && feature_i == 8'h02);
         end
         if (!drq_o) begin
            wcnt_r <= 9'h000;
         end else if (data_valid_i) begin
            wcnt_r <= wcnt_r + 9'h001;
         end
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_ok;
      done_o && status_o == 8'h40 && error_o == 8'h00;
   endsequence
   sequence s_abort;
      done_o && status_o == 8'h41 && error_o == 8'h04;
   endsequence
   a_lock_enter: assert property (sec && feature_i == 8'h02 && sec_state_o == 2'h0 |-> ##2 s_ok ##0 sec_state_o == 2'h1)
      else $error("lock not entered");
   a_freeze_enter: assert property (sec && feature_i == 8'h04 && sec_state_o != 2'h2 |-> ##2 s_ok ##0 sec_state_o == 2'h2)
      else $error("freeze not entered");
   a_guard_abort: assert property (sec && guarded |-> ##2 s_abort)
      else $error("guarded command not aborted");
   a_tries_zero: assert property (sec && feature_i == 8'h03 && tries_o == 3'h0 |-> ##1 !drq_o ##1 s_abort)
      else $error("unlock at zero tries not refused");
   a_sector_count: assert property ($fell(drq_o) |-> wcnt_r == 9'h100 ##1 done_o)
      else $error("sector length or completion wrong");
   a_unlock_drop: assert property ($fell(drq_o) ##1 s_abort |-> tries_o == $past(tries_o, 2) - 3'h1)
      else $error("tries not decremented");
   a_status_pair: assert property (done_o |-> s_ok or s_abort) else $error("bad completion code");
   a_head_field: assert property (done_o |-> head_o == (lba_mode_i ? max_addr_i[27:24] : max_head_i))
      else $error("head field wrong");
   a_frozen_stay: assert property (sec_state_o == 2'h2 && !hard_reset_i |=> sec_state_o == 2'h2)
      else $error("frozen state left");
   a_plain_setmax: assert property (plain && feature_i inside {8'h01, 8'h03, 8'h04} |=> set_max_o)
      else $error("plain set-max not seen");
   a_native_again: assert property (plain && feature_i == 8'h02 |=> read_native_o)
      else $error("native read not seen");
endmodule
bind msfsm_top msfsm_top_chk #(.PWD_WORDS(PWD_WORDS), .WORD_W(WORD_W)) msfsm_top_chk_inst (.*);

/* sim/tb_top.sv */
/*
 Testbench of the max-address security handler.
 Assumes the handler, its checker and the host model are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
   reg clk_i, resetn_i, hard_reset_i, cmd_valid_i, lba_mode_i, slow, sm, rn;
   reg [7:0] cmd_code_i, feature_i;
   reg [27:0] max_addr_i;
   reg [3:0] max_head_i;
   reg [15:0] key, k1;
   wire data_valid_i, busy_o, drq_o, done_o, set_max_o, read_native_o;
   wire [15:0] data_i;
   wire [7:0] status_o, error_o;
   wire [3:0] head_o;
   wire [1:0] sec_state_o;
   wire [2:0] tries_o;
   integer fail_count, n_tests, seed, i;
   msfsm_top msfsm_top_inst (.*);
   msfsm_host msfsm_host_inst (.clk_i(clk_i), .drq_i(drq_o), .slow_i(slow), .key_i(key),
      .data_valid_o(data_valid_i), .data_o(data_i));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", n_tests, fail_count);
         if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   function [3:0] exp_head(input l, input [27:0] a, input [3:0] h);
      exp_head = l ? a[27:24] : h;
   endfunction
   function [15:0] exp_resp(input ab);
      exp_resp = ab ? 16'h4104 : 16'h4000;
   endfunction
   task chk(input [63:0] name, input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[ERR] %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task step(input [7:0] c, input [7:0] f, input w, input ab, input [1:0] st, input [2:0] tr, input [1:0] sr);
      integer n;
      begin
         @(negedge clk_i);
         key = w ? ~k1 : k1;
         slow = $random(seed);
         lba_mode_i = $random(seed);
         max_addr_i = $random(seed);
         max_head_i = $random(seed);
         cmd_code_i = c;
         feature_i = f;
         cmd_valid_i = 1'b1;
         @(negedge clk_i);
         cmd_valid_i = 1'b0;
         sm = 1'b0;
         rn = 1'b0;
         n = 0;
         while (c == 8'hf9 && done_o !== 1'b1 && !rn && n < 900) begin
            sm = sm | (set_max_o === 1'b1);
            rn = read_native_o === 1'b1;
            n = n + 1;
            @(negedge clk_i);
         end
         while (busy_o !== 1'b0 || drq_o !== 1'b0) begin
            n = n + 1;
            if (n > 900) begin
               chk("timeout", 1, 0);
               end_sim;
            end
            @(negedge clk_i);
         end
         if (c == 8'hf9) begin
            chk("marked", {sm, rn}, sr);
            chk("status", {status_o, error_o}, exp_resp(ab));
            chk("head", head_o, exp_head(lba_mode_i, max_addr_i, max_head_i));
         end
         chk("state", {sec_state_o, tries_o}, {st, tr});
      end
   endtask
   task pwr(input hard);
      begin
         @(negedge clk_i);
         hard_reset_i = hard;
         resetn_i = hard;
         repeat (2) @(negedge clk_i);
         hard_reset_i = 1'b0;
         resetn_i = 1'b1;
         chk("reset", {sec_state_o, tries_o}, 5'h05);
      end
   endtask
   initial begin
      seed = 11045;
      fail_count = 0;
      n_tests = 0;
      resetn_i = 1'b0;
      hard_reset_i = 1'b0;
      cmd_valid_i = 1'b0;
      cmd_code_i = 8'h00;
      feature_i = 8'h00;
      lba_mode_i = 1'b0;
      max_addr_i = 28'h0000000;
      max_head_i = 4'h0;
      slow = 1'b0;
      k1 = $random(seed);
      key = k1;
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      resetn_i = 1'b1;
      chk("reset", {status_o, error_o, head_o, sec_state_o, tries_o}, 25'h0800005);
      step(8'hf9, 8'h01, 0, 0, 0, 5, 0);
      step(8'hf9, 8'h02, 0, 0, 1, 5, 0);
      step(8'hf9, 8'h02, 0, 1, 1, 5, 0);
      step(8'hf9, 8'h01, 0, 1, 1, 5, 0);
      for (i = 4; i >= 0; i = i - 1) step(8'hf9, 8'h03, 1, 1, 1, i[2:0], 0);
      step(8'hf9, 8'h03, 0, 1, 1, 0, 0);
      pwr(1);
      step(8'hf9, 8'h01, 0, 0, 0, 5, 0);
      step(8'hf9, 8'h02, 0, 0, 1, 5, 0);
      step(8'hf9, 8'h03, 0, 0, 0, 5, 0);
      step(8'hf9, 8'h02, 0, 0, 1, 5, 0);
      step(8'hf9, 8'h04, 0, 0, 2, 5, 0);
      for (i = 1; i <= 5; i = i + 1) step(8'hf9, i[7:0], 0, 1, 2, 5, 0);
      step(8'hf8, 8'h00, 0, 0, 2, 5, 0);
      step(8'hf9, 8'h01, 0, 1, 2, 5, 0);
      pwr(0);
      step(8'hf9, 8'h03, 0, 1, 0, 4, 0);
      step(8'hf8, 8'h00, 0, 0, 0, 4, 0);
      step(8'hf9, 8'h01, 0, 0, 0, 4, 2);
      step(8'hf8, 8'h00, 0, 0, 0, 4, 0);
      step(8'hf9, 8'h02, 0, 0, 0, 4, 1);
      step(8'hf9, 8'h03, 0, 0, 0, 4, 2);
      step(8'hf8, 8'h00, 0, 0, 0, 4, 0);
      step(8'hf9, 8'h04, 0, 0, 0, 4, 2);
      step(8'hf9, 8'h05, 0, 1, 0, 4, 0);
      step(8'hf9, 8'h04, 0, 0, 2, 4, 0);
      end_sim;
   end
endmodule
